// ---- rtl/host_port_rate_limit_pkg.sv ----
// Purpose: shared constants and types for the host port rate limit register bank
// Assumes: 16-bit host register words, byte addresses on the host register port
// Notes:   one name per number; the module body uses only these names
package host_port_rate_limit_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] host_port_control_three_off         = 8'ha2;
  localparam logic [7:0] host_port_ingress_rate_low_prio_off  = 8'ha4;
  localparam logic [7:0] host_port_ingress_rate_high_prio_off = 8'ha6;
  localparam logic [7:0] host_port_egress_rate_low_prio_off   = 8'ha8;
  localparam logic [7:0] host_port_egress_rate_high_prio_off  = 8'haa;

  // ---------------------------------------------------------------
  // field positions and write masks
  // ---------------------------------------------------------------
  localparam int         code_w          = 7;
  localparam int         code_even_lsb   = 0;    // priority 0 / 2 field
  localparam int         code_odd_lsb    = 8;    // priority 1 / 3 field
  localparam int         egress_en_bit   = 7;
  localparam int         preamble_bit    = 0;
  localparam int         ifg_bit         = 1;
  localparam int         mode_lsb        = 2;
  localparam logic [15:0] rate_wr_mask   = 16'h7f7f;
  localparam logic [15:0] egr0_wr_mask   = 16'h7fff;
  localparam logic [15:0] ctrl3_wr_mask  = 16'h000f;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] rate_rst       = 16'h0000;
  localparam logic [15:0] ctrl3_rst      = 16'h0002;
  localparam logic [6:0]  code_no_limit  = 7'h00;

  // ---------------------------------------------------------------
  // byte counting and timing
  // ---------------------------------------------------------------
  localparam logic [11:0] ifg_bytes      = 12'h00c;
  localparam logic [11:0] preamble_bytes = 12'h008;
  localparam int          clk_mhz        = 50;
  localparam int          refill_ns      = 1000;
  localparam int          refill_cycles  = (refill_ns * clk_mhz + 999) / 1000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_all, mode_bc_mc_flood, mode_bc_mc, mode_bc
  } limit_mode_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  prio;
    logic [10:0] len;      // frame bytes, header to crc
    logic        is_bcast;
    logic        is_mcast;
    logic        is_flood;
  } frame_req_t;

endpackage : host_port_rate_limit_pkg

// ---- rtl/host_port_rate_limit_regs.sv ----
// Purpose: host port per-priority ingress/egress rate limit registers and limiter
// Assumes: single clock, host register strobes and frame requests synchronous
// Notes:   one byte-credit bucket per direction and priority
//
// Operation
// - ingress low register bits 14:8 limit received priority 1 frames
// - ingress low register bits 6:0 limit received priority 0 frames
// - ingress high register bits 14:8 limit received priority 3 frames
// - ingress high register bits 6:0 limit received priority 2 frames
// - egress low register bits 14:8 limit transmitted priority 1 frames
// - egress low register bits 6:0 limit transmitted priority 0 frames
// - egress high register bits 14:8 limit transmitted priority 3 frames
// - egress high register bits 6:0 limit transmitted priority 2 frames
// - code zero, the reset value, means no limit at all
// - egress limiting only while egress low register bit 7 is set
// - ingress mode picks counted frames: all, bc/mc/flood, bc/mc, bc
// - gap control adds 12 bytes per frame to both directions' cost
// - preamble control adds 8 bytes per frame to both directions' cost
`timescale 1ns/1ps
module host_port_rate_limit_regs
  import host_port_rate_limit_pkg::*;
#(
  parameter int          credit_w        = 16,
  parameter int          rate_step_bytes = 1,
  parameter logic [15:0] bucket_max      = 16'h4000
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // host register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [1:0]  reg_be,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_r,
  // frame requests, index 0 ingress, index 1 egress
  input  wire frame_req_t  ing_req,
  input  wire frame_req_t  egr_req,
  // verdicts, one cycle after a request
  output logic             ing_pass_r,
  output logic             ing_drop_r,
  output logic             egr_pass_r,
  output logic             egr_drop_r
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  // control three sits here as well: mode and byte counting steer the limiter
  logic [15:0] ing_low_r, ing_high_r, egr_low_r, egr_high_r, ctrl3_r;
  logic [15:0] ing_low_nxt, ing_high_nxt, egr_low_nxt, egr_high_nxt, ctrl3_nxt;

  // byte-lane merge with reserved bits forced to zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0]  = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    return v & msk;
  endfunction : merge

  // address decode
  wire logic hit_ctrl3 = reg_addr == host_port_control_three_off;
  wire logic hit_il    = reg_addr == host_port_ingress_rate_low_prio_off;
  wire logic hit_ih    = reg_addr == host_port_ingress_rate_high_prio_off;
  wire logic hit_el    = reg_addr == host_port_egress_rate_low_prio_off;
  wire logic hit_eh    = reg_addr == host_port_egress_rate_high_prio_off;

  assign ctrl3_nxt    = (reg_wr && hit_ctrl3) ? merge(ctrl3_r, reg_wdata, reg_be, ctrl3_wr_mask)
                                              : ctrl3_r;
  assign ing_low_nxt  = (reg_wr && hit_il) ? merge(ing_low_r, reg_wdata, reg_be, rate_wr_mask)
                                           : ing_low_r;
  assign ing_high_nxt = (reg_wr && hit_ih) ? merge(ing_high_r, reg_wdata, reg_be, rate_wr_mask)
                                           : ing_high_r;
  assign egr_low_nxt  = (reg_wr && hit_el) ? merge(egr_low_r, reg_wdata, reg_be, egr0_wr_mask)
                                           : egr_low_r;
  assign egr_high_nxt = (reg_wr && hit_eh) ? merge(egr_high_r, reg_wdata, reg_be, rate_wr_mask)
                                           : egr_high_r;

  // read mux, unmapped addresses read zero
  // a write and a read in one cycle: the read returns the word before the write
  wire logic [15:0] rdata_sel =
      hit_ctrl3 ? ctrl3_r : hit_il ? ing_low_r : hit_ih ? ing_high_r :
      hit_el ? egr_low_r : hit_eh ? egr_high_r : 16'h0000;

  // registers and read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl3_r     <= ctrl3_rst;
      ing_low_r   <= rate_rst;
      ing_high_r  <= rate_rst;
      egr_low_r   <= rate_rst;
      egr_high_r  <= rate_rst;
      reg_rdata_r <= 16'h0000;
    end else begin
      ctrl3_r     <= ctrl3_nxt;
      ing_low_r   <= ing_low_nxt;
      ing_high_r  <= ing_high_nxt;
      egr_low_r   <= egr_low_nxt;
      egr_high_r  <= egr_high_nxt;
      reg_rdata_r <= reg_rd ? rdata_sel : reg_rdata_r;
    end
  end

  // ---------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------
  // entries 0 to 3 are ingress priorities, 4 to 7 egress priorities
  logic [6:0] code_w_arr [8]; // index {dir, prio}
  assign code_w_arr[0] = ing_low_r[code_even_lsb +: code_w];
  assign code_w_arr[1] = ing_low_r[code_odd_lsb +: code_w];
  assign code_w_arr[2] = ing_high_r[code_even_lsb +: code_w];
  assign code_w_arr[3] = ing_high_r[code_odd_lsb +: code_w];
  assign code_w_arr[4] = egr_low_r[code_even_lsb +: code_w];
  assign code_w_arr[5] = egr_low_r[code_odd_lsb +: code_w];
  assign code_w_arr[6] = egr_high_r[code_even_lsb +: code_w];
  assign code_w_arr[7] = egr_high_r[code_odd_lsb +: code_w];

  // egress needs its enable bit; ingress limiting has no enable of its own
  wire logic        egress_en = egr_low_r[egress_en_bit];
  wire limit_mode_t mode      = limit_mode_t'(ctrl3_r[mode_lsb +: 2]);

  // which ingress frames count against the limit
  logic ing_counted;
  always_comb begin
    unique case (mode)
      mode_all:         ing_counted = 1'b1;
      mode_bc_mc_flood: ing_counted = ing_req.is_bcast | ing_req.is_mcast | ing_req.is_flood;
      mode_bc_mc:       ing_counted = ing_req.is_bcast | ing_req.is_mcast;
      mode_bc:          ing_counted = ing_req.is_bcast;
    endcase
  end

  // per-frame overhead bytes shared by both directions
  wire logic [11:0] overhead =
      (ctrl3_r[ifg_bit] ? ifg_bytes : 12'h000) +
      (ctrl3_r[preamble_bit] ? preamble_bytes : 12'h000);
  wire logic [11:0] ing_cost = {1'b0, ing_req.len} + overhead;
  wire logic [11:0] egr_cost = {1'b0, egr_req.len} + overhead;

  // code to bytes per refill interval; linear table, replace to match silicon
  function automatic logic [credit_w-1:0] rate_of(input logic [6:0] code);
    return credit_w'(int'(code) * rate_step_bytes);
  endfunction : rate_of

  // ---------------------------------------------------------------
  // refill tick
  // ---------------------------------------------------------------
  logic [15:0] tick_cnt_r;
  wire  logic  tick = tick_cnt_r == 16'(refill_cycles - 1);

  // free-running; one shared strobe keeps all buckets on the same interval
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) tick_cnt_r <= 16'h0000;
    else        tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end

  // ---------------------------------------------------------------
  // credit buckets
  // ---------------------------------------------------------------
  // limitation: an idle bucket banks up to bucket_max, so a burst can follow
  logic [credit_w-1:0] credit_r [8];
  logic [7:0]          limited_w;
  logic [7:0]          ok_w;

  for (genvar g = 0; g < 8; g++) begin : g_bucket
    localparam logic       dir  = (g >= 4);
    localparam logic [1:0] prio = 2'(g % 4);

    wire frame_req_t  req   = dir ? egr_req : ing_req;
    wire logic [11:0] cost  = dir ? egr_cost : ing_cost;
    wire logic        count = dir ? egress_en : ing_counted;
    wire logic        hit   = req.valid && (req.prio == prio);
    // zero code bypasses the bucket entirely
    assign limited_w[g] = count && (code_w_arr[g] != code_no_limit);
    assign ok_w[g]      = credit_r[g] >= credit_w'(cost);

    // refill runs even while limiting is off, so enabling starts from banked credit
    // deduct and refill in one step so neither is lost
    wire logic [credit_w:0] after_use =
        (hit && limited_w[g] && ok_w[g]) ? {1'b0, credit_r[g]} - (credit_w+1)'(cost)
                                         : {1'b0, credit_r[g]};
    wire logic [credit_w:0] after_fill =
        tick ? after_use + {1'b0, rate_of(code_w_arr[g])} : after_use;
    wire logic [credit_w-1:0] credit_nxt =
        (after_fill > (credit_w+1)'(bucket_max)) ? credit_w'(bucket_max)
                                                 : after_fill[credit_w-1:0];

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) credit_r[g] <= '0;
      else        credit_r[g] <= credit_nxt;
    end
  end

  // ---------------------------------------------------------------
  // verdicts
  // ---------------------------------------------------------------
  // verdict reads credit before this cycle's deduction and refill
  wire logic [2:0] ing_idx = {1'b0, ing_req.prio};
  wire logic [2:0] egr_idx = {1'b1, egr_req.prio};
  wire logic ing_ok = !limited_w[ing_idx] || ok_w[ing_idx];
  wire logic egr_ok = !limited_w[egr_idx] || ok_w[egr_idx];

  // excess frames are dropped rather than held; no buffer here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ing_pass_r <= 1'b0;
      ing_drop_r <= 1'b0;
      egr_pass_r <= 1'b0;
      egr_drop_r <= 1'b0;
    end else begin
      ing_pass_r <= ing_req.valid && ing_ok;
      ing_drop_r <= ing_req.valid && !ing_ok;
      egr_pass_r <= egr_req.valid && egr_ok;
      egr_drop_r <= egr_req.valid && !egr_ok;
    end
  end

endmodule : host_port_rate_limit_regs

// ---- tb/host_port_rate_limit_checker.sv ----
// Purpose: port assertions for the rate limit register bank
// Assumes: verdict and read timing as handed over
// Notes:   attached by bind below
`timescale 1ns/1ps
module host_port_rate_limit_checker
  import host_port_rate_limit_pkg::*;
(
  // clock, reset, host port
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_rdata_r,
  // frame side
  input wire frame_req_t  ing_req,
  input wire frame_req_t  egr_req,
  input wire logic        ing_pass_r,
  input wire logic        ing_drop_r,
  input wire logic        egr_pass_r,
  input wire logic        egr_drop_r
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // address decode seen from outside
  wire rate_hit = reg_addr inside {8'ha4, 8'ha6, 8'haa};
  wire mapped   = rate_hit || reg_addr inside {8'ha2, 8'ha8};
  ing_one_verdict_a: assert property (ing_req.valid |=> ing_pass_r ^ ing_drop_r)
    else $error("ingress verdict missing or doubled");
  ing_quiet_a: assert property (!ing_req.valid |=> !ing_pass_r && !ing_drop_r)
    else $error("ingress verdict without request");
  egr_one_verdict_a: assert property (egr_req.valid |=> egr_pass_r ^ egr_drop_r)
    else $error("egress verdict missing or doubled");
  egr_quiet_a: assert property (!egr_req.valid |=> !egr_pass_r && !egr_drop_r)
    else $error("egress verdict without request");
  rate_rsv_zero_a: assert property (reg_rd && rate_hit |=> !reg_rdata_r[15] && !reg_rdata_r[7])
    else $error("reserved rate bits read nonzero");
  egr_rsv_zero_a: assert property (reg_rd && reg_addr == 8'ha8 |=> !reg_rdata_r[15])
    else $error("reserved egress bit read nonzero");
  unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_r))
    else $error("read data moved without read");
  // main scenarios reached
  cover property (ing_req.valid ##1 ing_drop_r);
  cover property (egr_req.valid ##1 egr_drop_r);
  cover property (reg_rd && !mapped);
endmodule : host_port_rate_limit_checker

bind host_port_rate_limit_regs host_port_rate_limit_checker u_host_port_rate_limit_checker (
  .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata_r(reg_rdata_r), .ing_req(ing_req), .egr_req(egr_req), .ing_pass_r(ing_pass_r),
  .ing_drop_r(ing_drop_r), .egr_pass_r(egr_pass_r), .egr_drop_r(egr_drop_r));

// ---- tb/host_port_rate_limit_regs_tb_top.sv ----
// Purpose: self-checking bench for the rate limit register bank
// Assumes: credits start at zero, refill every 50 cycles, code times 1 byte
// Notes:   cost margins chosen so refill phase never flips a verdict
`timescale 1ns/1ps
module host_port_rate_limit_regs_tb_top
  import host_port_rate_limit_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and checking
  // ---------------------------------------------------------------
  logic        clock, rst_n, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [1:0]  reg_be;
  logic [15:0] reg_wdata, reg_rdata_r;
  frame_req_t  ing_req, egr_req;
  logic        ing_pass_r, ing_drop_r, egr_pass_r, egr_drop_r;
  int          error_cnt, compares;
  logic [7:0]  offs [4] = '{8'ha4, 8'ha6, 8'ha8, 8'haa};
  host_port_rate_limit_regs u_host_port_rate_limit_regs (
    .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .ing_req(ing_req),
    .egr_req(egr_req), .ing_pass_r(ing_pass_r), .ing_drop_r(ing_drop_r),
    .egr_pass_r(egr_pass_r), .egr_drop_r(egr_drop_r));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // strobes last one cycle, launched at the falling edge
  task automatic wr(logic [7:0] a, logic [1:0] be, logic [15:0] d);
    @(negedge clock);
    {reg_wr, reg_addr, reg_be, reg_wdata} = {1'b1, a, be, d};
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(negedge clock);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clock);
    reg_rd = 1'b0;
    check("read data", exp, reg_rdata_r);
  endtask : rd
  // class 0 unicast, 1 flooded, 2 multicast, 3 broadcast
  task automatic fr(bit egr, logic [1:0] p, logic [10:0] len, int cls, bit drop);
    frame_req_t f;
    f = '{1'b1, p, len, cls == 3, cls == 2, cls == 1};
    @(negedge clock);
    if (egr) egr_req = f;
    else ing_req = f;
    @(negedge clock);
    // verdict stands for one cycle only: judge it at this falling edge
    ing_req.valid = 1'b0;
    egr_req.valid = 1'b0;
    check(egr ? "egress verdict" : "ingress verdict", {14'h0, !drop, drop},
          egr ? {14'h0, egr_pass_r, egr_drop_r} : {14'h0, ing_pass_r, ing_drop_r});
  endtask : fr
  task automatic t_reset_masks();
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], 16'h0000);
      wr(offs[i], 2'b11, 16'hffff);
      rd(offs[i], (i == 2) ? egr0_wr_mask : rate_wr_mask);
      wr(offs[i], 2'b11, 16'h0000);
    end
    rd(8'ha2, ctrl3_rst);
    wr(8'ha4, 2'b01, 16'hffff);
    rd(8'ha4, 16'h007f);
    wr(8'ha4, 2'b11, 16'h0000);
    wr(8'hb0, 2'b11, 16'hffff);
    rd(8'hb0, 16'h0000);
  endtask : t_reset_masks
  // mid-run reset clears fields and any credit banked while codes were nonzero
  task automatic t_mid_reset();
    wr(8'ha4, 2'b11, 16'h0101);
    @(negedge clock);
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    rd(8'ha4, 16'h0000);
  endtask : t_mid_reset
  // one field limited at a time: only its priority and direction drop
  task automatic t_fields();
    for (int i = 0; i < 8; i++) begin
      wr(8'ha8, 2'b11, 16'h0080);
      wr(offs[i / 2], 2'b11, ((i / 2 == 2) ? 16'h0080 : 16'h0) | (16'h1 << (i % 2 * 8)));
      for (int p = 0; p < 4; p++) begin
        fr(i >= 4, 2'(p), 11'd64, 0, p == i % 4);
        fr(i < 4, 2'(p), 11'd64, 0, 1'b0);
      end
      wr(offs[i / 2], 2'b11, 16'h0);
    end
  endtask : t_fields
  task automatic t_egress_enable();
    wr(8'ha8, 2'b11, 16'h0101);
    fr(1'b1, 2'd0, 11'd64, 0, 1'b0);
    wr(8'ha8, 2'b11, 16'h0181);
    fr(1'b1, 2'd1, 11'd64, 0, 1'b1);
    wr(8'ha8, 2'b11, 16'h0000);
  endtask : t_egress_enable
  task automatic t_modes();
    wr(8'ha4, 2'b11, 16'h0001);
    for (int m = 0; m < 4; m++) begin
      wr(8'ha2, 2'b11, 16'(m * 4 + 2));
      for (int c = 0; c < 4; c++) fr(1'b0, 2'd0, 11'd64, c, c >= m);
    end
    wr(8'ha2, 2'b11, ctrl3_rst);
    wr(8'ha4, 2'b11, 16'h0000);
  endtask : t_modes
  // code 2 for about 1000 cycles gives 40 to 43 bytes of credit
  task automatic t_counts();
    wr(8'ha6, 2'b11, 16'h0200);
    wr(8'ha2, 2'b11, 16'h0003);
    repeat (1000) @(negedge clock);
    fr(1'b0, 2'd3, 11'd24, 0, 1'b1);
    wr(8'ha2, 2'b11, 16'h0000);
    fr(1'b0, 2'd3, 11'd24, 0, 1'b0);
    wr(8'ha2, 2'b11, ctrl3_rst);
  endtask : t_counts
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = '0;
    {ing_req, egr_req} = '0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    t_reset_masks();
    t_mid_reset();
    t_fields();
    t_egress_enable();
    t_modes();
    t_counts();
    complete_run();
  end
  // hang guard, about four and a half times the expected run
  initial begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
endmodule : host_port_rate_limit_regs_tb_top
